// >>> sim/alu_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////
// timing and refusal checks on the ports
module alu_checker
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // request
  input wire logic req_valid,
  input wire alu_pkg::alu_req_t req,
  // answer
  input wire logic done,
  input wire logic illegal,
  input wire logic div_zero,
  input wire logic [31:0] result,
  input wire alu_pkg::alu_flags_t condition_flags
);
  import alu_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // byte subtract of an immediate
  sequence sub_bimm_s;
    req_valid && req.op == OP_SUB && req.size == SZ_BYTE && req.use_imm;
  endsequence
  // byte step other than one
  sequence bstep_s;
    req_valid && req.op inside {OP_INC, OP_DECREMENT} &&
    req.size == SZ_BYTE && req.imm[1:0] != 2'h1;
  endsequence
  // constant add or subtract not longword
  sequence adds_s;
    req_valid && req.op inside {OP_ADDS, OP_ADDR_SUB} && req.size != SZ_LONG;
  endsequence
  // longword logic operation
  sequence lglog_s;
    req_valid && req.size == SZ_LONG &&
    req.op inside {OP_AND, OP_OR, OP_XOR, OP_NOT};
  endsequence
  done_next_a: assert property (req_valid |=> done)
    else $error("no done after request");
  done_idle_a: assert property (!req_valid |=> !done)
    else $error("done without request");
  sub_refuse_a: assert property (sub_bimm_s |=> illegal)
    else $error("byte immediate subtract taken");
  step_refuse_a: assert property (bstep_s |=> illegal)
    else $error("byte step two taken");
  adds_refuse_a: assert property (adds_s |=> illegal)
    else $error("short constant add taken");
  refuse_hold_a: assert property (illegal |->
    $stable(condition_flags) && result == 32'h0 && done)
    else $error("refused request changed state");
  divz_flag_a: assert property (div_zero |-> condition_flags.z)
    else $error("divide by zero without z");
  logic_flag_a: assert property (lglog_s |=> !condition_flags.v &&
    condition_flags.z == (result == 32'h0) &&
    condition_flags.n == result[31])
    else $error("logic flags wrong");
endmodule

// >>> sim/tb_cpu_arith_logic_unit.sv
`timescale 1ns/1ps
////////////////////////////////////////
// self-checking bench for the alu
module tb_cpu_arith_logic_unit;
  import alu_pkg::*;
  logic sys_clk;
  logic rstn;
  logic req_valid;
  alu_req_t req;
  logic done;
  logic illegal;
  logic div_zero;
  logic [31:0] result;
  alu_flags_t condition_flags;
  logic [2:0] view_idx;
  logic [31:0] view_data;
  int num_errors;
  int comparisons;
  // device under test
  alu_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .done(done), .illegal(illegal), .div_zero(div_zero),
    .result(result), .condition_flags(condition_flags),
    .view_idx(view_idx), .view_data(view_data));
  ////////////////////////////////////////
  // compare and count
  task ck(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("Error %0t: got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask
  // one request, answer settled on return
  task ex(input alu_op_t o, input alu_size_t s, input logic [3:0] d,
    input logic [3:0] r, input logic u, input logic [31:0] im);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{o, s, d, r, u, im};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    ck(32'(done), 32'h1);
  endtask
  // load a full register
  task ld(input logic [2:0] r, input logic [31:0] v);
    ex(OP_AND, SZ_LONG, {1'b0, r}, 4'h0, 1'b1, 32'h0);
    ex(OP_OR, SZ_LONG, {1'b0, r}, 4'h0, 1'b1, v);
  endtask
  // read a register through the view port
  task rd(input logic [2:0] r, input logic [31:0] e);
    @(posedge sys_clk);
    view_idx <= r;
    @(posedge sys_clk);
    #1;
    ck(view_data, e);
  endtask
  ////////////////////////////////////////
  // add and subtract forms
  task t_arith;
    ld(3'h1, 32'h1234_5678);
    ld(3'h2, 32'h1111_1111);
    ex(OP_ADD, SZ_LONG, 4'h1, 4'h2, 1'b0, 32'h0);
    ck(result, 32'h2345_6789);
    ex(OP_SUB, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'h1);
    ck(32'(illegal), 32'h1);
    ex(OP_SUB, SZ_WORD, 4'h1, 4'h0, 1'b1, 32'h6789);
    ck(result, 32'h2345_0000);
    ck(32'(condition_flags), 32'h4);
    $display("t_arith done");
  endtask
  // steps and address constants
  task t_step;
    ex(OP_INC, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'h2);
    ck(32'(illegal), 32'h1);
    ex(OP_INC, SZ_BYTE, 4'h9, 4'h0, 1'b1, 32'h1);
    ck(result, 32'h2345_0001);
    ex(OP_DECREMENT, SZ_WORD, 4'h1, 4'h0, 1'b1, 32'h2);
    ck(result, 32'h2345_FFFF);
    ex(OP_ADDS, SZ_WORD, 4'h1, 4'h0, 1'b1, 32'h4);
    ck(32'(illegal), 32'h1);
    ex(OP_ADDS, SZ_LONG, 4'h1, 4'h0, 1'b1, 32'h4);
    ck(result, 32'h2346_0003);
    ex(OP_ADDR_SUB, SZ_LONG, 4'h1, 4'h0, 1'b1, 32'h2);
    ck(result, 32'h2346_0001);
    $display("t_step done");
  endtask
  // multiply and divide
  task t_muldiv;
    ld(3'h3, 32'h0303);
    ld(3'h4, 32'hFB);
    ex(OP_MULS, SZ_BYTE, 4'h3, 4'hC, 1'b0, 32'h0);
    ck(result, 32'h0000_FFF1);
    ld(3'h3, 32'h0303);
    ex(OP_MULU, SZ_BYTE, 4'h3, 4'hC, 1'b0, 32'h0);
    ck(result, 32'h0000_02F1);
    ld(3'h3, 32'hFFFF);
    ld(3'h4, 32'h2);
    ex(OP_MULU, SZ_WORD, 4'h3, 4'h4, 1'b0, 32'h0);
    ck(result, 32'h0001_FFFE);
    ld(3'h3, 32'hFFFF);
    ex(OP_MULS, SZ_WORD, 4'h3, 4'h4, 1'b0, 32'h0);
    ck(result, 32'hFFFF_FFFE);
    ld(3'h3, 32'h64);
    ld(3'h4, 32'h7);
    ex(OP_DIVU, SZ_BYTE, 4'h3, 4'hC, 1'b0, 32'h0);
    ck(result, 32'h0000_020E);
    ld(3'h3, 32'hFF9C);
    ex(OP_DIVS, SZ_BYTE, 4'h3, 4'hC, 1'b0, 32'h0);
    ck(result, 32'h0000_FEF2);
    ld(3'h3, 32'h1_0000);
    ld(3'h4, 32'h3);
    ex(OP_DIVU, SZ_WORD, 4'h3, 4'h4, 1'b0, 32'h0);
    ck(result, 32'h0001_5555);
    ex(OP_DIVU, SZ_WORD, 4'h3, 4'h5, 1'b0, 32'h0);
    ck(32'(div_zero), 32'h1);
    rd(3'h3, 32'h0001_5555);
    $display("t_muldiv done");
  endtask
  // compare, negate, complement, extension
  task t_unary;
    ex(OP_COMPARE, SZ_LONG, 4'h2, 4'h0, 1'b1, 32'h1111_1111);
    ck(32'(condition_flags), 32'h4);
    rd(3'h2, 32'h1111_1111);
    ex(OP_NEG, SZ_LONG, 4'h2, 4'h0, 1'b0, 32'h0);
    ck(result, 32'hEEEE_EEEF);
    ex(OP_NOT, SZ_LONG, 4'h2, 4'h0, 1'b0, 32'h0);
    ck(result, 32'h1111_1110);
    ld(3'h6, 32'h1234_8081);
    ex(OP_SIGN_EXT, SZ_WORD, 4'h6, 4'h0, 1'b0, 32'h0);
    ck(result, 32'h1234_FF81);
    ex(OP_SIGN_EXT, SZ_LONG, 4'h6, 4'h0, 1'b0, 32'h0);
    ck(result, 32'hFFFF_FF81);
    ex(OP_ZERO_EXT, SZ_LONG, 4'h6, 4'h0, 1'b0, 32'h0);
    ck(result, 32'h0000_FF81);
    ex(OP_ZERO_EXT, SZ_BYTE, 4'h6, 4'h0, 1'b0, 32'h0);
    ck(32'(illegal), 32'h1);
    $display("t_unary done");
  endtask
  // logic operations, immediate and register
  task t_logic;
    ld(3'h7, 32'hF0F0_F0F0);
    ex(OP_AND, SZ_LONG, 4'h7, 4'h0, 1'b1, 32'hFF00_FF00);
    ck(result, 32'hF000_F000);
    ex(OP_OR, SZ_LONG, 4'h7, 4'h0, 1'b1, 32'h0F0F_0000);
    ck(result, 32'hFF0F_F000);
    ex(OP_XOR, SZ_LONG, 4'h7, 4'h0, 1'b1, 32'hFFFF_FFFF);
    ck(result, 32'h00F0_0FFF);
    ex(OP_XOR, SZ_BYTE, 4'hF, 4'h9, 1'b0, 32'h0);
    ck(result, 32'h00F0_0FFE);
    ex(OP_AND, SZ_WORD, 4'h7, 4'h1, 1'b0, 32'h0);
    ck(result, 32'h00F0_0000);
    // carry still holds the borrow left by the negate
    ck(32'(condition_flags), 32'h5);
    ex(OP_OR, SZ_WORD, 4'hF, 4'h1, 1'b0, 32'h0);
    ck(result, 32'h00F1_0000);
    $display("t_logic done");
  endtask
  // decimal adjust after a byte add or subtract
  task t_bcd;
    ld(3'h1, 32'h45);
    ld(3'h2, 32'h38);
    ex(OP_ADD, SZ_BYTE, 4'h9, 4'hA, 1'b0, 32'h0);
    ex(OP_DECIMAL_ADD, SZ_BYTE, 4'h9, 4'h0, 1'b0, 32'h0);
    ck(result, 32'h0000_0083);
    ex(OP_DECIMAL_ADD, SZ_WORD, 4'h1, 4'h0, 1'b0, 32'h0);
    ck(32'(illegal), 32'h1);
    // 45 - 38 in decimal, low digit needs the subtract correction
    ld(3'h1, 32'h45);
    ex(OP_SUB, SZ_BYTE, 4'h9, 4'hA, 1'b0, 32'h0);
    ex(OP_DECIMAL_SUB, SZ_BYTE, 4'h9, 4'h0, 1'b0, 32'h0);
    ck(result, 32'h0000_0007);
    $display("t_bcd done");
  endtask
  ////////////////////////////////////////
  // verdict and end of run
  task conclude;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // watchdog
  initial
  begin
    #20000;
    num_errors++;
    conclude;
  end
  // main sequence
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    view_idx = 3'h0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_arith;
    t_step;
    t_muldiv;
    t_unary;
    t_logic;
    t_bcd;
    conclude;
  end
endmodule
// checker beside the design
bind alu_core alu_checker i_chk (.sys_clk(sys_clk), .rstn(rstn),
  .req_valid(req_valid), .req(req), .done(done), .illegal(illegal),
  .div_zero(div_zero), .result(result),
  .condition_flags(condition_flags));

// >>> src/alu_core.sv
`timescale 1ns/1ps
// What this block does
// - add or subtract register or immediate, B/W/L
// - byte immediate subtract is refused
// - increment/decrement by one or two
// - byte increment/decrement step one only
// - longword add/subtract constant 1, 2, 4
// - decimal adjust byte using flags
// - unsigned multiply 8x8 and 16x16
// - signed multiply byte or word
// - unsigned divide 16/8 and 32/16
// - signed divide same formats, two's complement
// - compare sets flags, no write
// - negate is zero minus operand
// - zero extend lower half
// - sign extend lower half
// - bitwise AND with register or immediate
// - bitwise OR with register or immediate
// - bitwise XOR with register or immediate
// - complement inverts every bit
// - register file with byte/word/long views
// - flags hold n, z, v, c
module alu_core
  import alu_pkg::*;
#(
  parameter int NREGS = ALU_REGS
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // instruction request
  input wire logic req_valid,
  input wire alu_pkg::alu_req_t req,
  // answer
  output logic done,
  output logic illegal,
  output logic div_zero,
  output logic [31:0] result,
  // state view
  output alu_pkg::alu_flags_t condition_flags,
  input wire logic [2:0] view_idx,
  output logic [31:0] view_data
);
  import alu_pkg::*;

  // the operand indexes only reach eight registers
  if (NREGS != ALU_REGS)
  begin : g_bad_nregs
    $error("alu_core serves eight 32-bit registers only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and operand views
  logic [31:0] regs_q [NREGS];
  alu_flags_t flags_q;
  logic [31:0] whole_d, whole_s;
  logic [7:0] rd_b, rs_b;
  logic [15:0] rd_w, rs_w;
  logic [31:0] rd_l, rs_l;

  // byte: idx[3] picks low/high byte, word: idx[3] picks E/R half
  assign whole_d = regs_q[req.dst[2:0]];
  assign whole_s = regs_q[req.src[2:0]];
  assign rd_b = req.dst[3] ? whole_d[7:0] : whole_d[15:8];
  assign rs_b = req.src[3] ? whole_s[7:0] : whole_s[15:8];
  assign rd_w = req.dst[3] ? whole_d[31:16] : whole_d[15:0];
  assign rs_w = req.src[3] ? whole_s[31:16] : whole_s[15:0];
  assign rd_l = whole_d;
  assign rs_l = whole_s;

  // operands normalised to 32 bits, source may be immediate
  logic [31:0] opa, opb, mask, msb;
  assign opa = (req.size == SZ_BYTE) ? {24'h0, rd_b} :
               (req.size == SZ_WORD) ? {16'h0, rd_w} : rd_l;
  assign opb = req.use_imm ? (req.imm & mask) :
               (req.size == SZ_BYTE) ? {24'h0, rs_b} :
               (req.size == SZ_WORD) ? {16'h0, rs_w} : rs_l;
  assign mask = (req.size == SZ_BYTE) ? 32'h0000_00FF :
                (req.size == SZ_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  assign msb = (req.size == SZ_BYTE) ? 32'h0000_0080 :
               (req.size == SZ_WORD) ? 32'h0000_8000 : 32'h8000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // adder shared by the add, subtract, step, compare and negate forms
  logic [31:0] step, add_a, add_b, sum;
  logic [32:0] sum_x;
  logic is_sub;
  logic [1:0] imm_step;
  assign imm_step = req.imm[1:0];
  // step: one or two for increment, 1/2/4 for address constants
  assign step = (req.op == OP_ADDS || req.op == OP_ADDR_SUB) ?
                ((req.imm[2]) ? 32'h4 : (imm_step == 2'h2) ? 32'h2 : 32'h1) :
                (imm_step == 2'h2) ? 32'h2 : 32'h1;
  assign is_sub = (req.op == OP_SUB) || (req.op == OP_DECREMENT) ||
                  (req.op == OP_ADDR_SUB) || (req.op == OP_COMPARE) ||
                  (req.op == OP_NEG);
  assign add_a = (req.op == OP_NEG) ? 32'h0 : opa;
  assign add_b = (req.op == OP_NEG) ? opa :
                 (req.op == OP_INC || req.op == OP_DECREMENT ||
                  req.op == OP_ADDS || req.op == OP_ADDR_SUB) ? step : opb;
  assign sum_x = is_sub ? ({1'b0, add_a} - {1'b0, add_b}) :
                          ({1'b0, add_a} + {1'b0, add_b});
  assign sum = sum_x[31:0] & mask;

  // carry out at the operand's top bit
  logic add_c, add_v, sa, sb, sr;
  assign sa = |(add_a & msb);
  assign sb = |(add_b & msb);
  assign sr = |(sum & msb);
  assign add_c = (req.size == SZ_BYTE) ? sum_x[8] :
                 (req.size == SZ_WORD) ? sum_x[16] : sum_x[32];
  assign add_v = is_sub ? ((sa != sb) && (sr != sa)) :
                          ((sa == sb) && (sr != sa));

  ////////////////////////////////////////////////////////////////////////////
  // decimal adjust on the destination byte
  logic [7:0] da_corr, da_res;
  logic da_c;
  always_comb
  begin
    da_corr = 8'h00;
    da_c = flags_q.c;
    if (req.op == OP_DECIMAL_ADD)
    begin
      // add correction when a digit is out of range or carried
      if (rd_b[3:0] > 4'h9)
      begin
        da_corr[3:0] = 4'h6;
      end
      if (flags_q.c || rd_b > 8'h99)
      begin
        da_corr[7:4] = 4'h6;
        da_c = 1'b1;
      end
    end
    else
    begin
      // subtract: six off the low digit is FA over the whole byte
      if (rd_b[3:0] > 4'h9)
      begin
        da_corr = 8'hFA;
      end
      if (flags_q.c)
      begin
        da_corr = da_corr + 8'hA0;
      end
    end
  end
  assign da_res = rd_b + da_corr;

  ////////////////////////////////////////////////////////////////////////////
  // multiply and divide
  logic [31:0] mul_u, mul_s, div_u, div_s;
  logic signed [15:0] mb_s;
  logic signed [31:0] mw_s;
  logic [15:0] dw_dvd_lo;
  logic div_by0, div_neg;
  // multiplicand and byte-divide dividend sit in the low word of the destination, word divide takes all 32 bits
  assign mb_s = $signed(whole_d[7:0]) * $signed(rs_b);
  assign mw_s = $signed(whole_d[15:0]) * $signed(rs_w);
  // byte form yields a word, word form a longword
  assign mul_u = (req.size == SZ_BYTE) ?
                 {16'h0, 16'(whole_d[7:0] * rs_b)} :
                 32'(rd_l[15:0] * rs_w);
  assign mul_s = (req.size == SZ_BYTE) ? {16'h0, mb_s} :
                 mw_s;
  assign div_by0 = (req.size == SZ_BYTE) ? (rs_b == 8'h0) :
                   (rs_w == 16'h0);
  assign dw_dvd_lo = whole_d[15:0];

  // unsigned: remainder in upper half, quotient in lower half
  always_comb
  begin
    div_u = 32'h0;
    if (!div_by0)
    begin
      if (req.size == SZ_BYTE)
      begin
        div_u = {16'h0, 8'(dw_dvd_lo % {8'h0, rs_b}),
                 8'(dw_dvd_lo / {8'h0, rs_b})};
      end
      else
      begin
        div_u = {16'(rd_l % {16'h0, rs_w}),
                 16'(rd_l / {16'h0, rs_w})};
      end
    end
  end

  // signed: quotient and remainder of two's complement values
  logic signed [31:0] sdvd, sdvs, sq, srm;
  assign sdvd = (req.size == SZ_BYTE) ? 32'($signed(dw_dvd_lo)) :
                $signed(rd_l);
  assign sdvs = (req.size == SZ_BYTE) ? 32'($signed(rs_b)) :
                32'($signed(rs_w));
  assign sq = div_by0 ? 32'sh0 : sdvd / sdvs;
  assign srm = div_by0 ? 32'sh0 : sdvd % sdvs;
  assign div_s = (req.size == SZ_BYTE) ?
                 {16'h0, srm[7:0], sq[7:0]} : {srm[15:0], sq[15:0]};
  assign div_neg = (req.size == SZ_BYTE) ? sq[7] : sq[15];

  ////////////////////////////////////////////////////////////////////////////
  // result selection, legality and flags
  logic [31:0] res;
  logic legal, wr_en;
  logic [31:0] res_msk;
  alu_flags_t f_d;
  always_comb
  begin
    res = 32'h0;
    legal = 1'b1;
    wr_en = 1'b1;
    f_d = flags_q;
    res_msk = mask;
    case (req.op)
      OP_ADD, OP_SUB, OP_INC, OP_DECREMENT, OP_COMPARE, OP_NEG:
      begin
        res = sum;
        f_d = '{n: sr, z: (sum == 32'h0), v: add_v, c: add_c};
        // a byte immediate cannot be subtracted
        legal = !(req.op == OP_SUB && req.use_imm &&
                  req.size == SZ_BYTE);
        if ((req.op == OP_INC || req.op == OP_DECREMENT) &&
            req.size == SZ_BYTE && imm_step != 2'h1)
        begin
          legal = 1'b0;
        end
        if (req.op == OP_INC || req.op == OP_DECREMENT)
        begin
          f_d.c = flags_q.c; // step ops leave carry
        end
        wr_en = (req.op != OP_COMPARE);
      end
      OP_ADDS, OP_ADDR_SUB:
      begin
        res = sum;
        legal = (req.size == SZ_LONG);
      end
      OP_DECIMAL_ADD, OP_DECIMAL_SUB:
      begin
        res = {24'h0, da_res};
        legal = (req.size == SZ_BYTE);
        f_d.n = da_res[7];
        f_d.z = (da_res == 8'h0);
        f_d.c = da_c;
      end
      OP_MULU, OP_MULS:
      begin
        res = (req.op == OP_MULU) ? mul_u : mul_s;
        legal = (req.size != SZ_LONG);
        res_msk = (req.size == SZ_BYTE) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        if (req.op == OP_MULS)
        begin
          f_d.n = (req.size == SZ_BYTE) ? res[15] : res[31];
          f_d.z = (res == 32'h0);
        end
      end
      OP_DIVU, OP_DIVS:
      begin
        res = (req.op == OP_DIVU) ? div_u : div_s;
        legal = (req.size != SZ_LONG);
        res_msk = (req.size == SZ_BYTE) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        wr_en = !div_by0;
        f_d.z = div_by0;
        f_d.n = (req.op == OP_DIVS) ? div_neg :
                ((req.size == SZ_BYTE) ? rs_b[7] : rs_w[15]);
      end
      OP_ZERO_EXT, OP_SIGN_EXT:
      begin
        legal = (req.size != SZ_BYTE);
        if (req.size == SZ_WORD)
        begin
          res = {16'h0, (req.op == OP_SIGN_EXT) ? {8{rd_w[7]}} : 8'h0,
                 rd_w[7:0]};
        end
        else
        begin
          res = {(req.op == OP_SIGN_EXT) ? {16{rd_l[15]}} : 16'h0,
                 rd_l[15:0]};
        end
        f_d = '{n: |(res & msb), z: (res == 32'h0), v: 1'b0, c: flags_q.c};
      end
      OP_AND, OP_OR, OP_XOR, OP_NOT:
      begin
        res = (req.op == OP_AND) ? (opa & opb) :
              (req.op == OP_OR) ? (opa | opb) :
              (req.op == OP_XOR) ? (opa ^ opb) :
              (~opa & mask);
        f_d = '{n: |(res & msb), z: (res == 32'h0), v: 1'b0,
                c: flags_q.c};
      end
      default:
      begin
        legal = 1'b0;
      end
    endcase
    legal = legal && (req.size != SZ_RSVD);
  end

  // merge result into the chosen view of the destination
  logic [31:0] merged;
  assign merged =
    (res_msk == 32'hFFFF_FFFF) ? res :
    (res_msk == 32'h0000_FFFF) ?
      (req.dst[3] && req.op != OP_MULU && req.op != OP_MULS &&
       req.op != OP_DIVU && req.op != OP_DIVS ?
       {res[15:0], whole_d[15:0]} : {whole_d[31:16], res[15:0]}) :
    (req.dst[3] ? {whole_d[31:8], res[7:0]} :
                  {whole_d[31:16], res[7:0], whole_d[7:0]});

  logic go;
  assign go = req_valid && legal;

  ////////////////////////////////////////////////////////////////////////////
  // register file update
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NREGS; i++)
      begin
        regs_q[i] <= ALU_REG_RST;
      end
    end
    else if (go && wr_en)
    begin
      regs_q[req.dst[2:0]] <= merged;
    end
  end

  // flags update
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_q <= alu_flags_t'(ALU_FLAG_RST);
    end
    else if (go)
    begin
      flags_q <= f_d;
    end
  end

  // answer registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      done <= 1'b0;
      illegal <= 1'b0;
      div_zero <= 1'b0;
      result <= 32'h0;
    end
    else
    begin
      done <= req_valid;
      illegal <= req_valid && !legal;
      div_zero <= go && (req.op == OP_DIVU || req.op == OP_DIVS) && div_by0;
      result <= go ? merged : 32'h0;
    end
  end

  assign condition_flags = flags_q;
  assign view_data = regs_q[view_idx];

endmodule

// >>> src/alu_pkg.sv
package alu_pkg;

  // operand sizes
  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_LONG,
    SZ_RSVD
  } alu_size_t;

  // operations
  typedef enum logic [4:0] {
    OP_ADD,
    OP_SUB,
    OP_INC,
    OP_DECREMENT,
    OP_ADDS,
    OP_ADDR_SUB,
    OP_DECIMAL_ADD,
    OP_DECIMAL_SUB,
    OP_MULU,
    OP_MULS,
    OP_DIVU,
    OP_DIVS,
    OP_COMPARE,
    OP_NEG,
    OP_ZERO_EXT,
    OP_SIGN_EXT,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_NOT
  } alu_op_t;

  // condition flags
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } alu_flags_t;

  // one instruction request
  typedef struct packed {
    alu_op_t op;
    alu_size_t size;
    logic [3:0] dst;
    logic [3:0] src;
    logic use_imm;
    logic [31:0] imm;
  } alu_req_t;

  localparam int ALU_REGS = 8;
  localparam logic [31:0] ALU_REG_RST = 32'h0000_0000;
  localparam logic [3:0] ALU_FLAG_RST = 4'h0;
  localparam int ALU_LAT = 1;

endpackage
